//--- hdl/pccr_lp_divider.sv
`timescale 1ns/1ps
module pccr_lp_divider (
	input wire logic clock_i, // Core clock
	input wire logic rst_i, // Asynchronous reset, active high
	input wire logic tick_i, // One pulse per source clock edge
	input wire logic [pccr_pkg::DIV_W-1:0] code_i, // Power-of-two exponent
	output logic tick_o // One pulse per 2**code_i input pulses
);
	logic [pccr_pkg::DIV_CNT_W-1:0] cnt_r;
	logic [pccr_pkg::DIV_CNT_W-1:0] cnt_nxt;
	logic [pccr_pkg::DIV_CNT_W:0] mask_wide;
	logic [pccr_pkg::DIV_CNT_W-1:0] mask;

	// Code zero gives an all-zero mask, so every input pulse passes
	assign mask_wide = (8'h01 << code_i) - 8'h01;
	assign mask = mask_wide[pccr_pkg::DIV_CNT_W-1:0];
	assign tick_o = tick_i & ((cnt_r & mask) == mask);
	assign cnt_nxt = tick_i ? cnt_r + 7'h01 : cnt_r;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 7'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

//--- hdl/pccr_pin_sync.sv
`timescale 1ns/1ps
module pccr_pin_sync (
	input wire logic clock_i, // Core clock
	input wire logic rst_i, // Asynchronous reset, active high
	input wire logic pin_i, // Asynchronous pin level
	output logic level_o, // Synchronised level
	output logic rise_o // One-cycle pulse on a rising edge
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign level_o = s2_r;
	assign rise_o = s2_r & ~s3_r;
endmodule

//--- hdl/pccr_pkg.sv
package pccr_pkg;
	// Register addresses in the processor's X I/O space
	localparam logic [15:0] ADDR_CTRL_ONE = 16'hfffd;
	localparam logic [15:0] ADDR_CTRL_ZERO = 16'hfffc;

	// Control register zero fields
	localparam int MULT_LSB = 0;
	localparam int MULT_W = 12;
	localparam int PREDIV_LO_LSB = 12;
	localparam int PREDIV_LO_W = 4;

	// Control register one fields
	localparam int DIV_LSB = 0;
	localparam int DIV_W = 3;
	localparam int LOW_RANGE_BIT = 3;
	localparam int DRIVE_OFF_BIT = 4;
	localparam int KEEP_BIT = 5;
	localparam int PLL_ON_BIT = 6;
	localparam int GATE_BIT = 7;
	localparam int PREDIV_HI_LSB = 9;
	localparam int PREDIV_HI_W = 3;
	localparam int PREDIV_W = 7;

	// Reset values of the fields that are not parameters of the top module, and read data for unmapped addresses
	localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
	localparam logic KEEP_RESET = 1'b0;
	localparam logic PLL_ON_RESET = 1'b0;
	localparam logic GATE_RESET = 1'b0;
	localparam logic [15:0] RDATA_RESET = 16'h0000;
	localparam logic [15:0] RDATA_UNMAPPED = 16'h0000;

	// Multiplier codes up to this value mean a factor of four or less
	localparam logic [MULT_W-1:0] MULT_SMALL_MAX = 12'h003;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int LOCK_TIME_NS = 100000;
	localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CNT_W = 12;
	localparam logic [LOCK_CNT_W-1:0] LOCK_LOAD = LOCK_CNT_W'(LOCK_CYCLES - 1);
	localparam logic [LOCK_CNT_W-1:0] LOCK_ZERO = 12'h000;
	localparam int DIV_CNT_W = 7;
	localparam logic [1:0] STRETCH_TICKS = 2'h2;
	localparam logic [1:0] INIT_LOAD = 2'h2;
	localparam logic [1:0] INIT_DONE = 2'h3;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} pccr_xio_req_s;

	typedef enum logic [1:0] {
		LOCK_OFF,
		LOCK_WAIT,
		LOCK_HELD
	} pccr_lock_e;
endpackage

//--- hdl/pccr_regs.sv
`timescale 1ns/1ps
// What this block does
// - Low four predivider code bits live in control zero bits 12 to 15.
// - High three predivider code bits live in control one bits 9 to 11.
// - Predivision factor is the seven-bit code plus one, 1 to 128.
// - Writing a new predivider code drops lock, which returns after a delay.
// - Low-power divider divides by two to the power of its 3-bit code.
// - Changing only the low-power divider code keeps lock.
// - Divider update stretches the instruction cycle only when factor is four or less.
// - Reset clears the low-power divider code, dividing by one.
// - Control one bit 3 selects reduced crystal amplifier gain.
// - Crystal range change while the loop runs drops lock and reacquires.
// - Control one bit 4 forces crystal drive pin high, stopping the oscillator.
// - Crystal drive bit change with factor above four drops lock and reacquires.
// - Control one bit 5 keeps loop and oscillator running in Stop; reset clears.
// - Keep bit set, enable clear: oscillator runs, loop off in Stop.
// - Control one bit 6 selects loop clocks; clear bypasses and stops the loop.
// - Software may set or clear the loop enable bit at any time.
// - The loop enable bit is loaded from the init pin at reset.
// - Control one bit 7 holds clock output high; clear gives 50% clock.
// - Clock output pin toggles in every state but Stop.
// - Control one bits 8 and 12 to 15 read as zero.
// - Control one is a 16-bit read/write X I/O register, reset zero except bit 6, loaded from the init pin.
// - Multiplier code in control zero bits 0 to 11, factor code plus one.
// - Writing a new multiplier code drops lock, which returns after a delay.
// - Enable bit picks bypass or divider source, then halved for core and pin.
module pccr_regs #(
	parameter logic [pccr_pkg::PREDIV_W-1:0] PREDIV_RESET = 7'h00, // Predivider code at reset
	parameter logic [pccr_pkg::MULT_W-1:0] MULT_RESET = 12'h000, // Multiplier code at reset
	parameter logic LOW_RANGE_RESET = 1'b0, // Crystal range bit at reset
	parameter logic DRIVE_OFF_RESET = 1'b0 // Crystal drive disable bit at reset
) (
	input wire logic clock_i, // Core clock, 20 MHz
	input wire logic rst_i, // Asynchronous reset, active high
	input wire pccr_pkg::pccr_xio_req_s xio_req_i, // X I/O access request
	output logic [15:0] xio_rdata_o, // Read data, one cycle after a read
	input wire logic external_clock_input_i, // External clock pin level
	input wire logic vco_clock_i, // VCO output level
	input wire logic pll_init_pin_i, // Enable strap pin
	input wire logic stop_i, // Core is in the Stop state
	output logic core_clk_en_o, // One pulse per internal core cycle
	output logic cycle_stretch_o, // Instruction cycle is being lengthened
	output logic clock_output_pin_o, // Clock output pin level
	output logic crystal_drive_force_o, // Crystal drive pin held high
	output logic crystal_low_range_o, // Reduced amplifier transconductance
	output logic osc_run_o, // Crystal oscillator enabled
	output logic pll_run_o, // PLL and VCO enabled
	output logic pll_lock_o, // Lock indication
	output logic [7:0] input_predivide_factor_o, // Predivision factor 1 to 128
	output logic [12:0] multiplication_factor_o, // Multiplication factor 1 to 4096
	output logic [pccr_pkg::DIV_W-1:0] lowpower_divide_code_o // Low-power divider code
);
	logic [pccr_pkg::PREDIV_W-1:0] predivider_code_r;
	logic [pccr_pkg::PREDIV_W-1:0] predivider_code_nxt;
	logic [pccr_pkg::MULT_W-1:0] multiplier_code_r;
	logic [pccr_pkg::MULT_W-1:0] multiplier_code_nxt;
	logic [pccr_pkg::DIV_W-1:0] lowpower_divide_code_r;
	logic [pccr_pkg::DIV_W-1:0] lowpower_divide_code_nxt;
	logic crystal_low_range_r;
	logic crystal_low_range_nxt;
	logic crystal_drive_off_r;
	logic crystal_drive_off_nxt;
	logic keep_running_in_stop_r;
	logic keep_running_in_stop_nxt;
	logic pll_on_r;
	logic pll_on_nxt;
	logic clock_pin_gate_r;
	logic clock_pin_gate_nxt;
	logic [15:0] xio_rdata_r;
	logic [15:0] xio_rdata_nxt;
	logic [1:0] init_cnt_r;
	logic [1:0] init_cnt_nxt;
	pccr_pkg::pccr_lock_e lock_state_r;
	pccr_pkg::pccr_lock_e lock_state_nxt;
	logic [pccr_pkg::LOCK_CNT_W-1:0] lock_cnt_r;
	logic [pccr_pkg::LOCK_CNT_W-1:0] lock_cnt_nxt;
	logic pll_run_prev_r;
	logic [1:0] stretch_cnt_r;
	logic [1:0] stretch_cnt_nxt;
	logic phase_r;
	logic core_en_r;
	logic pin_clk_r;

	logic hit_one;
	logic hit_zero;
	logic wr_one;
	logic wr_zero;
	logic init_load;
	logic init_pin_level;
	logic ext_rise;
	logic vco_rise;
	logic lpd_tick;
	logic src_tick;
	logic [15:0] ctrl_one_view;
	logic [15:0] ctrl_zero_view;
	logic [pccr_pkg::PREDIV_LO_W-1:0] wd_prediv_lo;
	logic [pccr_pkg::PREDIV_HI_W-1:0] wd_prediv_hi;
	logic [pccr_pkg::MULT_W-1:0] wd_mult;
	logic [pccr_pkg::DIV_W-1:0] wd_div;
	logic mult_small;
	logic prediv_chg;
	logic mult_chg;
	logic div_chg;
	logic range_chg;
	logic drive_chg;
	logic relock_req;
	logic pll_run;
	logic osc_run;

	pccr_pin_sync u_ext_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(external_clock_input_i),
		.level_o(),
		.rise_o(ext_rise)
	);

	pccr_pin_sync u_vco_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(vco_clock_i),
		.level_o(),
		.rise_o(vco_rise)
	);

	pccr_pin_sync u_init_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(pll_init_pin_i),
		.level_o(init_pin_level),
		.rise_o()
	);

	pccr_lp_divider u_lpd (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_i(vco_rise),
		.code_i(lowpower_divide_code_r),
		.tick_o(lpd_tick)
	);

	// Register decode
	assign hit_one = xio_req_i.addr == pccr_pkg::ADDR_CTRL_ONE;
	assign hit_zero = xio_req_i.addr == pccr_pkg::ADDR_CTRL_ZERO;
	assign wr_one = xio_req_i.wr & hit_one;
	assign wr_zero = xio_req_i.wr & hit_zero;
	assign wd_prediv_lo = xio_req_i.wdata[pccr_pkg::PREDIV_LO_LSB +: pccr_pkg::PREDIV_LO_W];
	assign wd_prediv_hi = xio_req_i.wdata[pccr_pkg::PREDIV_HI_LSB +: pccr_pkg::PREDIV_HI_W];
	assign wd_mult = xio_req_i.wdata[pccr_pkg::MULT_LSB +: pccr_pkg::MULT_W];
	assign wd_div = xio_req_i.wdata[pccr_pkg::DIV_LSB +: pccr_pkg::DIV_W];

	// Strap is sampled when the synchroniser has filled after release
	assign init_load = init_cnt_r == pccr_pkg::INIT_LOAD;
	assign init_cnt_nxt = (init_cnt_r == pccr_pkg::INIT_DONE) ? init_cnt_r : init_cnt_r + 2'h1;

	assign predivider_code_nxt = {wr_one ? wd_prediv_hi : predivider_code_r[6:4],
		wr_zero ? wd_prediv_lo : predivider_code_r[3:0]};
	assign multiplier_code_nxt = wr_zero ? wd_mult : multiplier_code_r;
	assign lowpower_divide_code_nxt = wr_one ? wd_div : lowpower_divide_code_r;
	assign crystal_low_range_nxt = wr_one ? xio_req_i.wdata[pccr_pkg::LOW_RANGE_BIT]
		: crystal_low_range_r;
	assign crystal_drive_off_nxt = wr_one ? xio_req_i.wdata[pccr_pkg::DRIVE_OFF_BIT]
		: crystal_drive_off_r;
	assign keep_running_in_stop_nxt = wr_one ? xio_req_i.wdata[pccr_pkg::KEEP_BIT]
		: keep_running_in_stop_r;
	assign pll_on_nxt = init_load ? init_pin_level
		: (wr_one ? xio_req_i.wdata[pccr_pkg::PLL_ON_BIT] : pll_on_r);
	assign clock_pin_gate_nxt = wr_one ? xio_req_i.wdata[pccr_pkg::GATE_BIT]
		: clock_pin_gate_r;

	// Read views; reserved bits are zero
	assign ctrl_one_view = {4'h0, predivider_code_r[6:4], 1'b0, clock_pin_gate_r, pll_on_r,
		keep_running_in_stop_r, crystal_drive_off_r, crystal_low_range_r,
		lowpower_divide_code_r};
	assign ctrl_zero_view = {predivider_code_r[3:0], multiplier_code_r};
	assign xio_rdata_nxt = !xio_req_i.rd ? xio_rdata_r
		: (hit_one ? ctrl_one_view : (hit_zero ? ctrl_zero_view : pccr_pkg::RDATA_UNMAPPED));

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			predivider_code_r <= PREDIV_RESET;
			multiplier_code_r <= MULT_RESET;
			lowpower_divide_code_r <= pccr_pkg::DIV_RESET;
			crystal_low_range_r <= LOW_RANGE_RESET;
			crystal_drive_off_r <= DRIVE_OFF_RESET;
			keep_running_in_stop_r <= pccr_pkg::KEEP_RESET;
			pll_on_r <= pccr_pkg::PLL_ON_RESET;
			clock_pin_gate_r <= pccr_pkg::GATE_RESET;
			xio_rdata_r <= pccr_pkg::RDATA_RESET;
			init_cnt_r <= 2'h0;
		end else begin
			predivider_code_r <= predivider_code_nxt;
			multiplier_code_r <= multiplier_code_nxt;
			lowpower_divide_code_r <= lowpower_divide_code_nxt;
			crystal_low_range_r <= crystal_low_range_nxt;
			crystal_drive_off_r <= crystal_drive_off_nxt;
			keep_running_in_stop_r <= keep_running_in_stop_nxt;
			pll_on_r <= pll_on_nxt;
			clock_pin_gate_r <= clock_pin_gate_nxt;
			xio_rdata_r <= xio_rdata_nxt;
			init_cnt_r <= init_cnt_nxt;
		end
	end

	// Events that disturb the loop
	assign mult_small = multiplier_code_r <= pccr_pkg::MULT_SMALL_MAX;
	assign prediv_chg = (wr_zero & (wd_prediv_lo != predivider_code_r[3:0]))
		| (wr_one & (wd_prediv_hi != predivider_code_r[6:4]));
	assign mult_chg = wr_zero & (wd_mult != multiplier_code_r);
	assign div_chg = wr_one & (wd_div != lowpower_divide_code_r);
	assign range_chg = wr_one & (xio_req_i.wdata[pccr_pkg::LOW_RANGE_BIT] != crystal_low_range_r);
	assign drive_chg = wr_one & (xio_req_i.wdata[pccr_pkg::DRIVE_OFF_BIT] != crystal_drive_off_r);
	// Divider changes are absent here on purpose
	assign relock_req = prediv_chg | mult_chg | range_chg
		| (drive_chg & ~mult_small);

	// Stop handling: keep bit decides, enable bit further gates the loop
	assign pll_run = pll_on_r & (~stop_i | keep_running_in_stop_r);
	assign osc_run = ~crystal_drive_off_r & (~stop_i | keep_running_in_stop_r);

	always_comb begin
		lock_state_nxt = lock_state_r;
		lock_cnt_nxt = lock_cnt_r;
		case (lock_state_r)
			pccr_pkg::LOCK_OFF: begin
				if (pll_run) begin
					lock_state_nxt = pccr_pkg::LOCK_WAIT;
					lock_cnt_nxt = pccr_pkg::LOCK_LOAD;
				end
			end
			pccr_pkg::LOCK_WAIT: begin
				if (!pll_run) begin
					lock_state_nxt = pccr_pkg::LOCK_OFF;
				end else if (relock_req) begin
					lock_cnt_nxt = pccr_pkg::LOCK_LOAD;
				end else if (lock_cnt_r == pccr_pkg::LOCK_ZERO) begin
					lock_state_nxt = pccr_pkg::LOCK_HELD;
				end else begin
					lock_cnt_nxt = lock_cnt_r - 12'h001;
				end
			end
			pccr_pkg::LOCK_HELD: begin
				if (!pll_run) begin
					lock_state_nxt = pccr_pkg::LOCK_OFF;
				end else if (relock_req) begin
					lock_state_nxt = pccr_pkg::LOCK_WAIT;
					lock_cnt_nxt = pccr_pkg::LOCK_LOAD;
				end
			end
			default: begin
				lock_state_nxt = pccr_pkg::LOCK_OFF;
			end
		endcase
	end

	// Clock source and output stage
	assign src_tick = pll_on_r ? lpd_tick : ext_rise;
	assign stretch_cnt_nxt = (div_chg & mult_small) ? pccr_pkg::STRETCH_TICKS
		: ((src_tick && stretch_cnt_r != 2'h0) ? stretch_cnt_r - 2'h1 : stretch_cnt_r);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			lock_state_r <= pccr_pkg::LOCK_OFF;
			lock_cnt_r <= pccr_pkg::LOCK_ZERO;
			pll_run_prev_r <= 1'b0;
			stretch_cnt_r <= 2'h0;
			phase_r <= 1'b0;
			core_en_r <= 1'b0;
			pin_clk_r <= 1'b1;
		end else begin
			lock_state_r <= lock_state_nxt;
			lock_cnt_r <= lock_cnt_nxt;
			pll_run_prev_r <= pll_run;
			stretch_cnt_r <= stretch_cnt_nxt;
			phase_r <= (src_tick & ~stop_i) ? ~phase_r : phase_r;
			core_en_r <= src_tick & phase_r & ~stop_i & (stretch_cnt_r == 2'h0);
			pin_clk_r <= clock_pin_gate_r | stop_i | phase_r;
		end
	end

	assign xio_rdata_o = xio_rdata_r;
	assign core_clk_en_o = core_en_r;
	assign cycle_stretch_o = stretch_cnt_r != 2'h0;
	assign clock_output_pin_o = pin_clk_r;
	assign crystal_drive_force_o = crystal_drive_off_r;
	assign crystal_low_range_o = crystal_low_range_r;
	assign osc_run_o = osc_run;
	assign pll_run_o = pll_run;
	assign pll_lock_o = lock_state_r != pccr_pkg::LOCK_WAIT;
	assign input_predivide_factor_o = {1'b0, predivider_code_r} + 8'h01;
	assign multiplication_factor_o = {1'b0, multiplier_code_r} + 13'h0001;
	assign lowpower_divide_code_o = lowpower_divide_code_r;

	property p_prediv_lo;
		@(posedge clock_i) disable iff (rst_i)
		wr_zero |=> predivider_code_r[3:0] == $past(wd_prediv_lo);
	endproperty
	a_prediv_lo: assert property (p_prediv_lo) else $error("low predivider bits lost");

	property p_prediv_hi;
		@(posedge clock_i) disable iff (rst_i)
		wr_one |=> ctrl_one_view[11:9] == $past(wd_prediv_hi);
	endproperty
	a_prediv_hi: assert property (p_prediv_hi) else $error("high predivider bits lost");

	property p_factor_range;
		@(posedge clock_i) disable iff (rst_i)
		input_predivide_factor_o != 8'h00 && input_predivide_factor_o <= 8'h80;
	endproperty
	a_factor_range: assert property (p_factor_range) else $error("factor out of range");

	property p_relock;
		@(posedge clock_i) disable iff (rst_i)
		(prediv_chg || mult_chg) && pll_run |=> !pll_lock_o ##1 (!pll_lock_o || !pll_run_prev_r);
	endproperty
	a_relock: assert property (p_relock) else $error("lock kept after code change");

	property p_div_keeps_lock;
		@(posedge clock_i) disable iff (rst_i)
		div_chg && !relock_req && pll_lock_o && $stable(pll_run) |=> pll_lock_o;
	endproperty
	a_div_keeps_lock: assert property (p_div_keeps_lock) else $error("divider lost lock");

	property p_stretch;
		@(posedge clock_i) disable iff (rst_i)
		div_chg |=> cycle_stretch_o == $past(mult_small) || $past(cycle_stretch_o);
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch does not match factor");

	property p_stop_off;
		@(posedge clock_i) disable iff (rst_i)
		stop_i && !keep_running_in_stop_r |-> !osc_run_o && !pll_run_o;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("clocks running in Stop");

	property p_stop_keep_osc;
		@(posedge clock_i) disable iff (rst_i)
		stop_i && keep_running_in_stop_r && !pll_on_r && !crystal_drive_off_r
			|-> osc_run_o && !pll_run_o;
	endproperty
	a_stop_keep_osc: assert property (p_stop_keep_osc) else $error("keep mode wrong");

	property p_gate_high;
		@(posedge clock_i) disable iff (rst_i)
		clock_pin_gate_r |=> clock_output_pin_o;
	endproperty
	a_gate_high: assert property (p_gate_high) else $error("clock pin not held high");

	property p_reserved_zero;
		@(posedge clock_i) disable iff (rst_i)
		xio_req_i.rd && hit_one |=> xio_rdata_o[8] == 1'b0 && xio_rdata_o[15:12] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	property p_drive_force;
		@(posedge clock_i) disable iff (rst_i)
		wr_one |=> crystal_drive_force_o == $past(xio_req_i.wdata[pccr_pkg::DRIVE_OFF_BIT]);
	endproperty
	a_drive_force: assert property (p_drive_force) else $error("drive disable not applied");

	property p_bypass_lock;
		@(posedge clock_i) disable iff (rst_i)
		!pll_run_prev_r && !pll_run |-> pll_lock_o;
	endproperty
	a_bypass_lock: assert property (p_bypass_lock) else $error("lock low with loop off");
endmodule

//--- verification/pccr_regs_bench.sv
`timescale 1ns/1ps
module pccr_regs_bench;
	localparam logic [15:0] A1 = pccr_pkg::ADDR_CTRL_ONE;
	localparam logic [15:0] A0 = pccr_pkg::ADDR_CTRL_ZERO;
	localparam int LOCK_WAIT = pccr_pkg::LOCK_CYCLES + 1;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	pccr_pkg::pccr_xio_req_s req = '0;
	logic ext_clk = 1'b0;
	logic vco_clk = 1'b0;
	logic strap = 1'b0;
	logic stop = 1'b0;
	logic [2:0] src_cnt = 3'h0;
	logic [15:0] rdata;
	logic core_en, stretch, pin, drv_force, low_range, osc_run, pll_run, lock;
	logic [7:0] pd_factor;
	logic [12:0] mult_factor;
	logic [2:0] div_code;
	int err_count = 0;
	int n_tests = 0;
	int i;
	int tg;
	int lo;
	int ce;

	always #25 clock_i = ~clock_i;

	// Slow crystal-side clock and faster VCO, both asynchronous to the core in spirit
	always @(posedge clock_i) begin
		src_cnt <= src_cnt + 3'h1;
		ext_clk <= src_cnt[2];
		vco_clk <= src_cnt[0];
	end

	pccr_regs u_pccr_regs (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.xio_req_i(req),
		.xio_rdata_o(rdata),
		.external_clock_input_i(ext_clk),
		.vco_clock_i(vco_clk),
		.pll_init_pin_i(strap),
		.stop_i(stop),
		.core_clk_en_o(core_en),
		.cycle_stretch_o(stretch),
		.clock_output_pin_o(pin),
		.crystal_drive_force_o(drv_force),
		.crystal_low_range_o(low_range),
		.osc_run_o(osc_run),
		.pll_run_o(pll_run),
		.pll_lock_o(lock),
		.input_predivide_factor_o(pd_factor),
		.multiplication_factor_o(mult_factor),
		.lowpower_divide_code_o(div_code)
	);

	task automatic report_and_stop;
		$display("Counts: %0d comparisons, %0d mismatches", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock_i);
		req.wr <= 1'b0;
		@(negedge clock_i);
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clock_i);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock_i);
		req.rd <= 1'b0;
		@(negedge clock_i);
		check(rdata, exp);
	endtask

	task automatic lock_drop_chk;
		int n;
		n = 0;
		while (lock === 1'b1 && n < 4) begin
			@(negedge clock_i);
			n++;
		end
		check({15'h0, lock}, 16'h0000);
		if (lock !== 1'b0) begin
			report_and_stop();
		end
		n = 0;
		while (lock !== 1'b1 && n < 3000) begin
			@(negedge clock_i);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, lock, 1'b1);
			report_and_stop();
		end
		check(16'((n > LOCK_WAIT - 3 && n < LOCK_WAIT + 3) ? LOCK_WAIT : n), 16'(LOCK_WAIT));
	endtask

	task automatic lock_hold_chk;
		repeat (12) begin
			@(negedge clock_i);
			check({15'h0, lock}, 16'h0001);
		end
	endtask

	task automatic pin_watch;
		logic last;
		tg = 0;
		lo = 0;
		ce = 0;
		last = pin;
		repeat (200) begin
			@(negedge clock_i);
			if (core_en === 1'b1) ce++;
			if (pin !== last) tg++;
			if (pin !== 1'b1) lo++;
			last = pin;
		end
	endtask

	initial begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		rd_chk(A1, 16'h0000);
		rd_chk(A0, 16'h0000);
		check({13'h0, div_code}, 16'h0000);
		wr(16'h1234, 16'hFFFF);
		rd_chk(16'h1234, 16'h0000);
		rd_chk(A1, 16'h0000);
		$display("Test reset values done");

		wr(A0, 16'hA123);
		rd_chk(A0, 16'hA123);
		check({3'h0, mult_factor}, 16'h0124);
		wr(A1, 16'h0E00);
		rd_chk(A1, 16'h0E00);
		check({8'h0, pd_factor}, 16'h007B);
		wr(A0, 16'hF000);
		check({8'h0, pd_factor}, 16'h0080);
		check({15'h0, lock}, 16'h0001);
		wr(A1, 16'h0000);
		wr(A0, 16'h0000);
		check({8'h0, pd_factor}, 16'h0001);
		check({3'h0, mult_factor}, 16'h0001);
		for (i = 0; i < 8; i++) begin
			wr(A1, 16'(i));
			check({13'h0, div_code}, 16'(i));
		end
		rd_chk(A1, 16'h0007);
		$display("Test field placement done");

		wr(A1, 16'h0018);
		check({14'h0, low_range, drv_force}, 16'h0003);
		check({15'h0, osc_run}, 16'h0000);
		wr(A1, 16'h0000);
		check({14'h0, low_range, drv_force}, 16'h0000);
		check({15'h0, osc_run}, 16'h0001);
		@(posedge clock_i);
		stop <= 1'b1;
		for (i = 0; i < 4; i++) begin
			wr(A1, 16'(i) << 5);
			check({14'h0, osc_run, pll_run}, {14'h0, i[0], i[0] & i[1]});
		end
		wr(A1, 16'h0000);
		pin_watch();
		check(16'(lo), 16'h0000);
		@(posedge clock_i);
		stop <= 1'b0;
		pin_watch();
		check(16'(tg > 8), 16'h0001);
		check(16'(ce * 2 + 2 >= tg && ce * 2 <= tg + 2), 16'h0001);
		wr(A1, 16'h0080);
		repeat (2) @(negedge clock_i);
		pin_watch();
		check(16'(lo), 16'h0000);
		wr(A1, 16'h0000);
		repeat (20) @(negedge clock_i);
		check({15'h0, lock}, 16'h0001);
		$display("Test pins and stop done");

		wr(A1, 16'h0040);
		rd_chk(A1, 16'h0040);
		lock_drop_chk();
		wr(A1, 16'h0043);
		i = 0;
		while (stretch !== 1'b1 && i < 4) begin
			@(negedge clock_i);
			i++;
		end
		check({15'h0, stretch}, 16'h0001);
		if (stretch !== 1'b1) begin
			report_and_stop();
		end
		lock_hold_chk();
		wr(A0, 16'h0000);
		lock_hold_chk();
		wr(A0, 16'h0005);
		lock_drop_chk();
		wr(A1, 16'h0040);
		repeat (12) begin
			@(negedge clock_i);
			check({15'h0, stretch}, 16'h0000);
		end
		check({15'h0, lock}, 16'h0001);
		wr(A1, 16'h0050);
		lock_drop_chk();
		wr(A1, 16'h0058);
		lock_drop_chk();
		wr(A0, 16'h1005);
		lock_drop_chk();
		wr(A1, 16'h0258);
		lock_drop_chk();
		check({8'h0, pd_factor}, 16'h0012);
		$display("Test lock behaviour done");

		@(posedge clock_i);
		strap <= 1'b1;
		rst_i <= 1'b1;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		rd_chk(A1, 16'h0040);
		rd_chk(A0, 16'h0000);
		$display("Test strap load done");
		report_and_stop();
	end
endmodule
